// [rtl/crt_meas_pkg.sv]
package crt_meas_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL       = 8'h00;
    localparam logic [7:0] A_TUBE_START = 8'h04;
    localparam logic [7:0] A_PIC_FIRST  = 8'h08;
    localparam logic [7:0] A_PIC_LAST   = 8'h0C;
    localparam logic [7:0] A_CUTOFF_R   = 8'h10;
    localparam logic [7:0] A_CUTOFF_G   = 8'h14;
    localparam logic [7:0] A_CUTOFF_B   = 8'h18;
    localparam logic [7:0] A_MEAS_BRT   = 8'h1C;
    localparam logic [7:0] A_LIM_THR    = 8'h20;
    localparam logic [7:0] A_LIM_MIN    = 8'h24;
    localparam logic [7:0] A_RES_CUT_R  = 8'h28;
    localparam logic [7:0] A_RES_CUT_G  = 8'h2C;
    localparam logic [7:0] A_RES_CUT_B  = 8'h30;
    localparam logic [7:0] A_RES_WD     = 8'h34;
    localparam logic [7:0] A_RES_MAX    = 8'h38;
    localparam logic [7:0] A_RES_MIN    = 8'h3C;
    localparam logic [7:0] A_STATUS     = 8'h40;
    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int CTRL_OFFSET_CHK = 0;
    localparam int CTRL_PIC_BW     = 1;
    localparam int CTRL_PIC_EN     = 2;
    localparam int CTRL_PIC_HWIN   = 3;
    localparam int CTRL_CLAMP_REF  = 4;
    // ----------------------------------------------------------------
    // Reset values and timing counts
    // ----------------------------------------------------------------
    localparam logic [9:0] TUBE_START_RST = 10'h010;
    localparam logic [9:0] PIC_FIRST_RST  = 10'h017;
    localparam logic [9:0] PIC_LAST_RST   = 10'h136;
    localparam logic [8:0] CUTOFF_RST     = 9'h100;
    localparam logic [7:0] LIM_THR_RST    = 8'hC0;
    localparam logic [7:0] LIM_MIN_RST    = 8'h40;
    localparam logic [7:0] MEAS_BRT_RST   = 8'h80;
    localparam logic [7:0] DEC_LEN_SMALL  = 8'hFE;
    localparam logic [7:0] DEC_LEN_LARGE  = 8'h7E;
    localparam logic [9:0] CUT_R_DELAY    = 10'h002;
    localparam logic [1:0] RECOVER_LINES  = 2'h3;
    localparam int         LPF_SHIFT      = 4;

    typedef enum logic [2:0] {
        T_IDLE    = 3'b000,
        T_OFFSET  = 3'b001,
        T_WAIT    = 3'b010,
        T_CUT_R   = 3'b011,
        T_CUT_G   = 3'b100,
        T_CUT_B   = 3'b101,
        T_WHITE   = 3'b110,
        T_RECOVER = 3'b111
    } tube_state_e;
endpackage

// [rtl/crt_measurement_sequencer.sv]
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// How it works
// - Sense input is a 1-bit stream decimated to 8 bits, two bandwidths.
// - Tube cycle starts only on a vertical blanking line; cutoff and whitedrive lines use small bandwidth only.
// - Whitedrive line asserts range select output b.
// - Picture min/max measured in active video, range select output a set.
// - Picture vertical window programmable by first and last line, one line allowed.
// - Per field a tube set (cutoff RGB, one whitedrive) and picture set (max, min).
// - Reading blue cutoff result arms the next tube measurement cycle.
// - Cutoff RGB in one field; whitedrive rotates one colour per field.
// - Offset check mode forces cutoff and whitedrive drive to zero.
// - Tube lines disable beam limiting and substitute measurement brightness.
// - Red cutoff line is two lines after the programmed start line.
// - Writing picture enable bit runs one field of picture measurement.
// - Picture measurement starts only at a field boundary, in active video.
// - Picture measurement bandwidth chosen by a control bit.
// - Small and large horizontal windows; tube always uses the small one.
// - Limiter offset adjust runs two lines before the red cutoff line.
// - Excess over threshold is low-pass filtered and lowers drive gains.
// - Limiter gain never falls below programmable minimum.
// - Three lines after whitedrive line before limited drive returns.
// - Half contrast input halves RGB drive gain.
// - Three 9-bit cutoff levels written by host drive cutoff outputs.
module crt_measurement_sequencer (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        line_start,
    input  wire logic        field_start,
    input  wire logic        vblank,
    input  wire logic        hblank,
    input  wire logic        active_video,
    input  wire logic        small_hwindow,
    input  wire logic        measure_converter_input,
    input  wire logic        half_contrast_in,
    input  wire logic [7:0]  normal_brightness,
    output logic             range_select_out_a,
    output logic             range_select_out_b,
    output logic             lim_disable,
    output logic             lim_offset_adjust,
    output logic [7:0]       brightness_out,
    output logic [2:0]       meas_gun_select,
    output logic             drive_force_zero,
    output logic [8:0]       cutoff_level_r,
    output logic [8:0]       cutoff_level_g,
    output logic [8:0]       cutoff_level_b,
    output logic [7:0]       digital_drive_gain,
    output logic [7:0]       ext_contrast_gain,
    output logic             blank_half_level
);
    import crt_meas_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic       offset_check, pic_bw_large, pic_hwin_large, clamp_ref;
    logic [9:0] tube_start, pic_first, pic_last;
    logic [8:0] cutoff_r, cutoff_g, cutoff_b;
    logic [7:0] meas_brt, lim_thr, lim_min;
    logic [7:0] res_cut_r, res_cut_g, res_cut_b, res_wd, res_max, res_min;
    logic [1:0] res_wd_col, wd_colour;
    logic       tube_armed, tube_run, pic_pending, pic_run;
    logic [7:0] run_max, run_min, gain;
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic [9:0] line_cnt;
    logic [1:0] recover_cnt;
    tube_state_e tstate;

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    function automatic logic [31:0] read_mux(input logic [7:0] a);
        unique case (a)
            A_CTRL:       read_mux = {27'h0, clamp_ref, pic_hwin_large,
                                      pic_pending | pic_run, pic_bw_large, offset_check};
            A_TUBE_START: read_mux = {22'h0, tube_start};
            A_PIC_FIRST:  read_mux = {22'h0, pic_first};
            A_PIC_LAST:   read_mux = {22'h0, pic_last};
            A_CUTOFF_R:   read_mux = {23'h0, cutoff_r};
            A_CUTOFF_G:   read_mux = {23'h0, cutoff_g};
            A_CUTOFF_B:   read_mux = {23'h0, cutoff_b};
            A_MEAS_BRT:   read_mux = {24'h0, meas_brt};
            A_LIM_THR:    read_mux = {24'h0, lim_thr};
            A_LIM_MIN:    read_mux = {24'h0, lim_min};
            A_RES_CUT_R:  read_mux = {24'h0, res_cut_r};
            A_RES_CUT_G:  read_mux = {24'h0, res_cut_g};
            A_RES_CUT_B:  read_mux = {24'h0, res_cut_b};
            A_RES_WD:     read_mux = {22'h0, res_wd_col, res_wd};
            A_RES_MAX:    read_mux = {24'h0, res_max};
            A_RES_MIN:    read_mux = {24'h0, res_min};
            A_STATUS:     read_mux = {16'h0, gain, wd_colour, tstate,
                                      pic_run, pic_pending, tube_armed};
            default:      read_mux = 32'h0000_0000;
        endcase
    endfunction

    logic addr_ok, rd_cut_b, wr_now;
    assign addr_ok  = hsel & hready & htrans[1] & (haddr[31:8] == 24'h0) & (haddr[1:0] == 2'b00);
    assign rd_cut_b = addr_ok & ~hwrite & (haddr[7:0] == A_RES_CUT_B);
    assign wr_now   = wr_pend;

    // Zero wait states: read data is registered in the address phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= addr_ok & hwrite;
            wr_addr   <= haddr[7:0];
            if (addr_ok & ~hwrite) begin
                hrdata <= read_mux(haddr[7:0]);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offset_check   <= 1'b0;
            pic_bw_large   <= 1'b0;
            pic_hwin_large <= 1'b0;
            clamp_ref      <= 1'b0;
            tube_start     <= TUBE_START_RST;
            pic_first      <= PIC_FIRST_RST;
            pic_last       <= PIC_LAST_RST;
            cutoff_r       <= CUTOFF_RST;
            cutoff_g       <= CUTOFF_RST;
            cutoff_b       <= CUTOFF_RST;
            meas_brt       <= MEAS_BRT_RST;
            lim_thr        <= LIM_THR_RST;
            lim_min        <= LIM_MIN_RST;
        end else if (wr_now) begin
            unique case (wr_addr)
                A_CTRL: begin
                    offset_check   <= hwdata[CTRL_OFFSET_CHK];
                    pic_bw_large   <= hwdata[CTRL_PIC_BW];
                    pic_hwin_large <= hwdata[CTRL_PIC_HWIN];
                    clamp_ref      <= hwdata[CTRL_CLAMP_REF];
                end
                A_TUBE_START: tube_start <= hwdata[9:0];
                A_PIC_FIRST:  pic_first  <= hwdata[9:0];
                A_PIC_LAST:   pic_last   <= hwdata[9:0];
                A_CUTOFF_R:   cutoff_r   <= hwdata[8:0];
                A_CUTOFF_G:   cutoff_g   <= hwdata[8:0];
                A_CUTOFF_B:   cutoff_b   <= hwdata[8:0];
                A_MEAS_BRT:   meas_brt   <= hwdata[7:0];
                A_LIM_THR:    lim_thr    <= hwdata[7:0];
                A_LIM_MIN:    lim_min    <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    a_hready_high: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> hreadyout && !hresp)
        else $error("slave stalled or errored");

    // ----------------------------------------------------------------
    // Line counter and decimator
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_cnt <= 10'h000;
        end else if (field_start) begin
            line_cnt <= 10'h000;
        end else if (line_start) begin
            line_cnt <= line_cnt + 10'h001;
        end
    end

    // Boxcar of 254 or 126 samples, one result every 255 or 127 clocks; long box is the small bandwidth
    logic       bw_large, smp_valid;
    logic [7:0] dec_cnt, ones, smp;
    assign bw_large = pic_run & pic_bw_large & (tstate == T_IDLE);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dec_cnt   <= 8'h00;
            ones      <= 8'h00;
            smp       <= 8'h00;
            smp_valid <= 1'b0;
        end else begin
            smp_valid <= 1'b0;
            if (dec_cnt >= (bw_large ? DEC_LEN_LARGE : DEC_LEN_SMALL)) begin
                dec_cnt   <= 8'h00;
                ones      <= 8'h00;
                smp_valid <= 1'b1;
                smp       <= bw_large ? {ones[6:0], 1'b0} : ones;
            end else begin
                dec_cnt <= dec_cnt + 8'h01;
                ones    <= ones + {7'h0, measure_converter_input};
            end
        end
    end

    // ----------------------------------------------------------------
    // Tube measurement sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tube_armed <= 1'b1;
            tube_run   <= 1'b0;
        end else begin
            if (field_start) begin
                tube_run <= tube_armed;
            end else if (tstate == T_RECOVER && recover_cnt == 2'h0 && line_start) begin
                tube_run <= 1'b0;
            end
            // A read in the consuming cycle keeps the cycle armed
            if (rd_cut_b) begin
                tube_armed <= 1'b1;
            end else if (field_start) begin
                tube_armed <= 1'b0;
            end
        end
    end

    a_cutb_rearm: assert property (@(posedge clk) disable iff (!nrst)
        rd_cut_b |=> tube_armed)
        else $error("blue cutoff read did not arm tube cycle");

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tstate      <= T_IDLE;
            recover_cnt <= 2'h0;
        end else if (field_start) begin
            tstate <= T_IDLE;
        end else if (line_start) begin
            unique case (tstate)
                T_IDLE: begin
                    if (tube_run && vblank && line_cnt + 10'h001 == tube_start) begin
                        tstate <= T_OFFSET;
                    end
                end
                T_OFFSET: tstate <= T_WAIT;
                T_WAIT:   tstate <= T_CUT_R;
                T_CUT_R:  tstate <= T_CUT_G;
                T_CUT_G:  tstate <= T_CUT_B;
                T_CUT_B:  tstate <= T_WHITE;
                T_WHITE: begin
                    tstate      <= T_RECOVER;
                    recover_cnt <= RECOVER_LINES - 2'h1;
                end
                T_RECOVER: begin
                    if (recover_cnt == 2'h0) begin
                        tstate <= T_IDLE;
                    end else begin
                        recover_cnt <= recover_cnt - 2'h1;
                    end
                end
            endcase
        end
    end

    a_cutr_line: assert property (@(posedge clk) disable iff (!nrst)
        $rose(tstate == T_CUT_R) |-> line_cnt == tube_start + CUT_R_DELAY)
        else $error("red cutoff line not two lines after start");
    a_white_recover: assert property (@(posedge clk) disable iff (!nrst)
        (tstate == T_WHITE && line_start && !field_start) |=> tstate == T_RECOVER)
        else $error("whitedrive line not followed by recovery");

    // Small window only for tube lines, one result per line
    logic tube_meas, tube_smp;
    assign tube_meas = tstate inside {T_CUT_R, T_CUT_G, T_CUT_B, T_WHITE};
    assign tube_smp  = tube_meas & smp_valid & small_hwindow;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            res_cut_r  <= 8'h00;
            res_cut_g  <= 8'h00;
            res_cut_b  <= 8'h00;
            res_wd     <= 8'h00;
            res_wd_col <= 2'h0;
            wd_colour  <= 2'h0;
        end else begin
            if (tube_smp) begin
                unique case (tstate)
                    T_CUT_R: res_cut_r <= smp;
                    T_CUT_G: res_cut_g <= smp;
                    T_CUT_B: res_cut_b <= smp;
                    T_WHITE: begin
                        res_wd     <= smp;
                        res_wd_col <= wd_colour;
                    end
                    default: ;
                endcase
            end
            if (tstate == T_WHITE && line_start) begin
                wd_colour <= (wd_colour == 2'h2) ? 2'h0 : wd_colour + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Picture measurement
    // ----------------------------------------------------------------
    logic pic_win;
    assign pic_win = pic_run & active_video & (line_cnt >= pic_first) &
                     (line_cnt <= pic_last) & (pic_hwin_large | small_hwindow);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pic_pending <= 1'b0;
            pic_run     <= 1'b0;
            run_max     <= 8'h00;
            run_min     <= 8'hFF;
            res_max     <= 8'h00;
            res_min     <= 8'h00;
        end else begin
            // Host write wins over the field-start consumption
            if (wr_now && wr_addr == A_CTRL && hwdata[CTRL_PIC_EN]) begin
                pic_pending <= 1'b1;
            end else if (field_start) begin
                pic_pending <= 1'b0;
            end
            if (field_start) begin
                pic_run <= pic_pending;
                run_max <= 8'h00;
                run_min <= 8'hFF;
                if (pic_run) begin
                    res_max <= run_max;
                    res_min <= run_min;
                end
            end else if (pic_win && smp_valid) begin
                if (smp > run_max) begin
                    run_max <= smp;
                end
                if (smp < run_min) begin
                    run_min <= smp;
                end
            end
        end
    end

    a_pic_one_field: assert property (@(posedge clk) disable iff (!nrst)
        (field_start && !pic_pending) |=> !pic_run ##1 !pic_run)
        else $error("picture measurement ran past one field");

    // ----------------------------------------------------------------
    // Beam current limiter
    // ----------------------------------------------------------------
    logic [11:0] lpf;
    logic [7:0]  excess, atten;
    assign excess = (smp > lim_thr) ? smp - lim_thr : 8'h00;
    assign atten  = lpf[11:4];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lpf  <= 12'h000;
            gain <= 8'hFF;
        end else begin
            if (smp_valid && active_video && tstate == T_IDLE) begin
                lpf <= lpf + {4'h0, excess} - (lpf >> LPF_SHIFT);
            end
            gain <= (8'hFF - atten < lim_min) ? lim_min : 8'hFF - atten;
        end
    end

    a_gain_floor: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> gain >= $past(lim_min))
        else $error("limiter gain below lower limit");

    // ----------------------------------------------------------------
    // Output drive
    // ----------------------------------------------------------------
    logic override, force0;
    assign override = tstate != T_IDLE && tstate != T_OFFSET;
    assign force0   = offset_check & tube_meas;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            range_select_out_a <= 1'b0;
            range_select_out_b <= 1'b0;
            lim_disable        <= 1'b0;
            lim_offset_adjust  <= 1'b0;
            brightness_out     <= 8'h00;
            meas_gun_select    <= 3'h0;
            drive_force_zero   <= 1'b0;
            cutoff_level_r     <= 9'h000;
            cutoff_level_g     <= 9'h000;
            cutoff_level_b     <= 9'h000;
            digital_drive_gain <= 8'h00;
            ext_contrast_gain  <= 8'h00;
            blank_half_level   <= 1'b0;
        end else begin
            range_select_out_a <= pic_win;
            range_select_out_b <= tstate == T_WHITE;
            lim_disable        <= override;
            lim_offset_adjust  <= tstate == T_OFFSET;
            brightness_out     <= override ? meas_brt : normal_brightness;
            meas_gun_select    <= tstate == T_CUT_R ? 3'b001 :
                                  tstate == T_CUT_G ? 3'b010 :
                                  tstate == T_CUT_B ? 3'b100 :
                                  tstate == T_WHITE ? 3'b001 << wd_colour : 3'b000;
            drive_force_zero   <= force0;
            cutoff_level_r     <= force0 ? 9'h000 : cutoff_r;
            cutoff_level_g     <= force0 ? 9'h000 : cutoff_g;
            cutoff_level_b     <= force0 ? 9'h000 : cutoff_b;
            // External RGB keeps full contrast under half contrast
            digital_drive_gain <= override ? 8'hFF :
                                  half_contrast_in ? {1'b0, gain[7:1]} : gain;
            ext_contrast_gain  <= override ? 8'hFF : gain;
            blank_half_level   <= clamp_ref & (hblank | vblank);
        end
    end

    a_rsb_white: assert property (@(posedge clk) disable iff (!nrst)
        (tstate == T_WHITE) |=> range_select_out_b)
        else $error("range select b missing in whitedrive line");
    a_half_gain: assert property (@(posedge clk) disable iff (!nrst)
        (half_contrast_in && !override) |=> digital_drive_gain == {1'b0, $past(gain[7:1])})
        else $error("half contrast did not halve drive gain");
    a_offset_zero: assert property (@(posedge clk) disable iff (!nrst)
        (offset_check && tube_meas) |=> drive_force_zero && cutoff_level_r == 9'h000)
        else $error("offset check did not force zero drive");
    a_limiter_off: assert property (@(posedge clk) disable iff (!nrst)
        (tstate == T_CUT_R) |=> lim_disable && brightness_out == $past(meas_brt))
        else $error("limiter active during tube measurement");

endmodule // crt_measurement_sequencer

// [testbench/video_timing_model.sv]
`timescale 1ns/100ps
// ---------------------------------------------
// Video timing: short 64-clock lines, 24 lines
// ---------------------------------------------
module video_timing_model (
    input  wire logic clk,
    input  wire logic nrst,
    output logic      line_start,
    output logic      field_start,
    output logic      vblank,
    output logic      hblank,
    output logic      active_video,
    output logic      small_hwindow
);
    logic [5:0] h;
    logic [4:0] v;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            h <= 6'h00;
            v <= 5'h00;
        end else begin
            h <= h + 6'h01;
            if (h == 6'h3F) v <= (v == 5'h17) ? 5'h00 : v + 5'h01;
        end
    end
    // Short field keeps a tube cycle inside the blanking lines 0..11
    assign line_start    = (h == 6'h00);
    assign field_start   = line_start && (v == 5'h00);
    assign vblank        = (v < 5'h0C);
    assign hblank        = (h < 6'h08);
    assign active_video  = !vblank && !hblank;
    assign small_hwindow = (h > 6'h18) && (h < 6'h28);
endmodule // video_timing_model

// [testbench/test_crt_measurement_sequencer.sv]
`timescale 1ns/100ps
module test_crt_measurement_sequencer;
    import crt_meas_pkg::*;
    logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, half_contrast_in;
    logic line_start, field_start, vblank, hblank, active_video, small_hwindow;
    logic range_select_out_a, range_select_out_b, lim_disable, lim_offset_adjust;
    logic drive_force_zero, blank_half_level, measure_converter_input;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize, meas_gun_select, gun;
    logic [7:0]  normal_brightness, brightness_out, digital_drive_gain, ext_contrast_gain;
    logic [8:0]  cutoff_level_r, cutoff_level_g, cutoff_level_b;
    int          fail_count, tests_run, ofs, wd, dis, pic, gap, fz;
    assign hready = hreadyout;
    crt_measurement_sequencer i_crt_measurement_sequencer (.*);
    video_timing_model i_video_timing_model (.*);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds each phase until hready is seen high; entered just after an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        r = hrdata;
        chk(hresp, 0);
        if (n >= 50) begin fail_count++; finish_test(); end
    endtask
    // Samples mid-line so the one-cycle output lag never spills into a neighbour line
    task automatic field();
        int n, ln, lo;
        {n, ln, lo, ofs, wd, dis, pic, gap, fz} = '0;
        do begin @(posedge clk); n++; end while (field_start !== 1'b1 && n < 2000);
        repeat (1535) begin
            @(posedge clk);
            if (line_start === 1'b1) ln++;
            if (i_video_timing_model.h == 6'h20) begin
                if (lim_offset_adjust === 1'b1) begin ofs++; lo = ln; end
                if (range_select_out_b === 1'b1) begin wd++; gun = meas_gun_select; end
                if (lim_disable === 1'b1) dis++;
                if (drive_force_zero === 1'b1) fz++;
                if (range_select_out_a === 1'b1) pic++;
                if (meas_gun_select === 3'b001 && gap == 0) gap = ln - lo;
            end
        end
        if (n >= 2000) begin fail_count++; finish_test(); end
    endtask
    task automatic t_regs();
        bus(1'b1, A_TUBE_START, 32'h0000_0002);
        bus(1'b0, A_TUBE_START, 32'h0000_0000);
        chk(r, 32'h0000_0002);
        bus(1'b1, A_CUTOFF_R, 32'h0000_01AB);
        bus(1'b0, 8'h80, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        chk(cutoff_level_r, 9'h1AB);
    endtask
    task automatic t_tube();
        for (int c = 0; c < 3; c++) begin
            if (c == 2) bus(1'b1, A_CTRL, 32'h0000_0001);
            bus(1'b0, A_RES_CUT_B, 32'h0000_0000);
            field();
            chk(ofs, 1);
            chk(gap, 2);
            chk(wd, 1);
            chk(dis, 8);
            // Armed out of reset, the first field already used red
            chk(gun, 1 << ((c + 1) % 3));
            chk(fz, (c == 2) ? 4 : 0);
        end
        field();
        chk(dis, 0);
    endtask
    task automatic t_refuse();
        bus(1'b1, A_TUBE_START, 32'h0000_0014);
        bus(1'b0, A_RES_CUT_B, 32'h0000_0000);
        field();
        chk(dis, 0);
    endtask
    task automatic t_pic();
        bus(1'b1, A_PIC_FIRST, 32'h0000_000E);
        bus(1'b1, A_PIC_LAST, 32'h0000_000E);
        bus(1'b1, A_CTRL, 32'h0000_0004);
        field();
        chk(pic, 1);
        field();
        chk(pic, 0);
    endtask
    task automatic t_scart();
        logic p;
        bus(1'b1, A_LIM_MIN, 32'h0000_00FE);
        bus(1'b1, A_CTRL, 32'h0000_0010);
        half_contrast_in <= 1'b1;
        measure_converter_input <= 1'b1;
        // Two fields of excess current, then a line outside vertical blanking
        repeat (3872) @(posedge clk);
        repeat (64) begin
            p = hblank | vblank;
            @(posedge clk);
            chk(blank_half_level, p);
        end
        chk(ext_contrast_gain, 8'hFE);
        chk(digital_drive_gain, 8'h7F);
    endtask
    initial begin
        {nrst, hsel, hwrite, half_contrast_in, measure_converter_input} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        normal_brightness = 8'h55;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_regs();
        t_tube();
        t_refuse();
        t_pic();
        t_scart();
        finish_test();
    end
endmodule // test_crt_measurement_sequencer
